// [rdo_buf2.sv]
/*
 Two-entry buffer for three-bit data groups; ready on the filling side
 comes straight from a flip-flop.
 Assumes one clock and an active-low asynchronous reset.
*/
`timescale 1ns/10ps
`default_nettype none

module rdo_buf2
    import rdo_pkg::*;
(
    input  wire logic   clk_i,
    input  wire logic   nrst_i,
    rdo_stream_if.snk   in_s,
    rdo_stream_if.src   out_s
);

    rdo_buf_s st;
    rdo_buf_s next_st;
    logic     push;
    logic     pop;

    assign out_s.valid = (st.cnt != 2'h0);
    assign out_s.data  = st.d0;
    assign in_s.ready  = st.rdy;

    always_comb
    begin
        next_st = st;
        push    = in_s.valid && st.rdy;
        pop     = out_s.valid && out_s.ready;
        if (pop)
        begin
            next_st.d0 = st.d1;
        end
        if (push)
        begin
            if (st.cnt == 2'h0 || (st.cnt == 2'h1 && pop))
                next_st.d0 = in_s.data;
            else
                next_st.d1 = in_s.data;
        end
        next_st.cnt = 2'(st.cnt + {1'b0, push} - {1'b0, pop});
        next_st.rdy = (next_st.cnt != 2'h2);
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            st <= '{d0: 3'h0, d1: 3'h0, cnt: 2'h0, rdy: 1'b1};
        else
            st <= next_st;
    end

endmodule : rdo_buf2

`default_nettype wire

// [rdo_defs.svh]
/*
 Readout control constants: marker line order, marker action masks,
 register widths and hold register field layout.
 Assumes inclusion by bare name from the package and the design files.
*/
`ifndef RDO_DEFS_SVH
`define RDO_DEFS_SVH

// Widths, accumulator fill limit and group step
`define RDO_MARK_LINES   18
`define RDO_TRI_BITS     3
`define RDO_SR_BITS      12
`define RDO_WORD_BITS    15
`define RDO_CNT_BITS     4
`define RDO_ACC_LIMIT    4'h9
`define RDO_TRI_STEP     4'h3

// Marker line index
`define RDO_MK_F0C9      0
`define RDO_MK_F0C11     1
`define RDO_MK_F0C12     2
`define RDO_MK_F0C13     3
`define RDO_MK_F1C1      4
`define RDO_MK_F1C2      5
`define RDO_MK_F1C14     6
`define RDO_MK_F2C1      7
`define RDO_MK_F2C2      8
`define RDO_MK_F8C9      9
`define RDO_MK_F8C11     10
`define RDO_MK_F8C12     11
`define RDO_MK_F8C13     12
`define RDO_MK_F9C1      13
`define RDO_MK_F9C2      14
`define RDO_MK_F9C14     15
`define RDO_MK_F10C1     16
`define RDO_MK_F10C2     17

// Marker action masks
`define RDO_XA_MASK      18'h09249
`define RDO_XB_MASK      18'h12492
`define RDO_CLR_MASK     18'h24924
`define RDO_W2_MASK      18'h03018

// Hold register layout: first part in the top stages, second part below
`define RDO_W13_A_MSB    14
`define RDO_W13_A_LSB    9
`define RDO_W13_B_MSB    8
`define RDO_W13_A_SRMSB  5
`define RDO_W2_A_MSB     14
`define RDO_W2_A_LSB     12
`define RDO_W2_B_MSB     11
`define RDO_W2_A_SRMSB   2

// Reset values
`define RDO_HOLD_RST     15'h0000
`define RDO_SR_RST       12'h000
`define RDO_MARK_RST     18'h00000

`endif

// [rdo_exp_model.sv]
/*
 Far-side experimenter model: answers each ready pulse with a readout
 command and takes the parallel word from the hold register.
 Assumes ready and word are registered on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
`include "rdo_defs.svh"

module rdo_exp_model
(
    input  wire logic                        clk_i,
    input  wire logic                        nrst_i,
    input  wire logic                        ready_i,
    input  wire logic [`RDO_WORD_BITS-1:0]   word_i,
    output logic                             cmd_o,
    output logic [`RDO_WORD_BITS-1:0]        word_o,
    output logic [7:0]                       cnt_o
);
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            cmd_o  <= 1'b0;
            word_o <= 15'h0000;
            cnt_o  <= 8'h00;
        end
        else
        begin
            cmd_o <= ready_i;
            if (ready_i)
            begin
                word_o <= word_i;
                cnt_o  <= cnt_o + 8'h01;
            end
        end
    end
endmodule : rdo_exp_model

`default_nettype wire

// [rdo_pkg.sv]
/*
 Types for the readout control: state enum and the state records of the
 main block and of the two-entry buffer.
 Assumes rdo_defs.svh on the include path.
*/
`include "rdo_defs.svh"

package rdo_pkg;

    typedef enum logic [1:0] {
        RDO_IDLE  = 2'b01,
        RDO_SHIFT = 2'b10
    } rdo_state_e;

    typedef struct packed {
        logic                         strb_s1;
        logic                         strb_s2;
        logic                         strb_s3;
        logic                         strb_f;
        logic                         strb_prev;
        logic                         lock_s1;
        logic                         lock_s2;
        logic                         lock_s3;
        logic                         lock_f;
        logic [`RDO_MARK_LINES-1:0]   mark_s1;
        logic [`RDO_MARK_LINES-1:0]   mark_s2;
        logic [`RDO_MARK_LINES-1:0]   mark_s3;
        logic [`RDO_MARK_LINES-1:0]   mark_f;
        rdo_state_e                   state;
        logic [`RDO_SR_BITS-1:0]      acc;
        logic [`RDO_CNT_BITS-1:0]     acc_n;
        logic [`RDO_SR_BITS-1:0]      sh;
        logic [`RDO_CNT_BITS-1:0]     sh_cnt;
        logic [`RDO_WORD_BITS-1:0]    hold;
        logic                         ready;
        logic                         clear;
    } rdo_main_s;

    typedef struct packed {
        logic [`RDO_TRI_BITS-1:0]     d0;
        logic [`RDO_TRI_BITS-1:0]     d1;
        logic [1:0]                   cnt;
        logic                         rdy;
    } rdo_buf_s;

endpackage : rdo_pkg

// [rdo_readout.sv]
/*
 Split-word parallel readout control: gathers three-bit groups, shifts each
 word part serially into a twelve-stage shift register, moves it into its
 stages of a fifteen-bit hold register on strobe-qualified marker times,
 raises ready on the second part and clears the hold register afterwards.
 Assumes marker lines, blank strobe and lockout arrive from outside the
 clock domain; data groups and part_go_i come from logic on clk_i.
*/
// Summary of operation
// - Three fifteen-bit words per sequence, two parts
// - Words handled again in frames eight to ten
// - Parts shifted in, then to own stages
// - Ready per word, hold cleared after readout
// - Data gathered three bits per channel time
// - Serial shift during blank, LSB enters last
// - Parallel move in following channel's blank
// - Clear only after word can be taken
// - Eighteen marker lines drive the sequencing
// - Data channels fixed per frame pair
// - Word one first part: six bits
// - Strobe with F0C9 moves word one first part
// - Nine-bit second part at F0C11 strobe
// - Second-part transfer pulse is the ready
// - F0C12 strobe clears hold after word one
// - Word two three-bit first part at F0C13
// - Word two twelve-bit part at F1C1, ready
// - F1C2 strobe clears hold after word two
// - Word three like word one, own markers
// - Twelve-stage shift register feeds fifteen-bit hold
// - Lockout blocks transfer and ready gates
// - Blank strobe is final enable everywhere
`timescale 1ns/10ps
`default_nettype none
`include "rdo_defs.svh"

module rdo_readout
    import rdo_pkg::*;
(
    input  wire logic                          clk_i,
    input  wire logic                          nrst_i,
    input  wire logic                          strobe_n_i,
    input  wire logic [`RDO_MARK_LINES-1:0]    marker_i,
    input  wire logic                          lockout_i,
    input  wire logic [`RDO_TRI_BITS-1:0]      tri_data_i,
    input  wire logic                          tri_valid_i,
    output logic                               tri_ready_o,
    input  wire logic                          part_go_i,
    output logic [`RDO_WORD_BITS-1:0]          hold_o,
    output logic                               ready_o,
    output logic                               clear_o
);

    rdo_main_s st;
    rdo_main_s next_st;
    logic      blank_edge;
    logic      xa_evt;
    logic      xb_evt;
    logic      clr_evt;
    logic      word2;

    rdo_stream_if in_s ();
    rdo_stream_if out_s ();

    assign in_s.valid  = tri_valid_i;
    assign in_s.data   = tri_data_i;
    assign tri_ready_o = in_s.ready;

    // Input buffer, takes up to two groups before stalling the source while the part is shifting
    rdo_buf2 u_buf (
        .clk_i  (clk_i),
        .nrst_i (nrst_i),
        .in_s   (in_s),
        .out_s  (out_s)
    );

    // Drain only while idle and the accumulator has room
    assign out_s.ready = (st.state == RDO_IDLE) && (st.acc_n <= `RDO_ACC_LIMIT) && !part_go_i;

    // Strobe-qualified marker events
    assign blank_edge = st.strb_prev && !st.strb_f;
    assign word2      = |(st.mark_f & `RDO_W2_MASK);
    assign xa_evt     = blank_edge && |(st.mark_f & `RDO_XA_MASK) && !st.lock_f;
    assign xb_evt     = blank_edge && |(st.mark_f & `RDO_XB_MASK) && !st.lock_f;
    assign clr_evt    = blank_edge && |(st.mark_f & `RDO_CLR_MASK);

    always_comb
    begin
        next_st = st;

        // Three-stage input filters
        next_st.strb_s1 = strobe_n_i;
        next_st.strb_s2 = st.strb_s1;
        next_st.strb_s3 = st.strb_s2;
        if (st.strb_s2 == st.strb_s3)
            next_st.strb_f = st.strb_s3;
        next_st.strb_prev = st.strb_f;
        next_st.lock_s1 = lockout_i;
        next_st.lock_s2 = st.lock_s1;
        next_st.lock_s3 = st.lock_s2;
        if (st.lock_s2 == st.lock_s3)
            next_st.lock_f = st.lock_s3;
        next_st.mark_s1 = marker_i;
        next_st.mark_s2 = st.mark_s1;
        next_st.mark_s3 = st.mark_s2;
        next_st.mark_f  = (st.mark_s2 & st.mark_s3) | (st.mark_f & (st.mark_s2 | st.mark_s3));

        // Accumulate three bits per channel time
        if (out_s.valid && out_s.ready)
        begin
            next_st.acc   = {st.acc[`RDO_SR_BITS-`RDO_TRI_BITS-1:0], out_s.data};
            next_st.acc_n = `RDO_CNT_BITS'(st.acc_n + `RDO_TRI_STEP);
        end

        // Serial load of a part into the shift register
        case (st.state)
            RDO_IDLE:
            begin
                if (part_go_i && st.acc_n != 4'h0)
                begin
                    next_st.state  = RDO_SHIFT;
                    next_st.sh     = `RDO_SR_RST;
                    next_st.sh_cnt = st.acc_n;
                end
            end
            RDO_SHIFT:
            begin
                next_st.sh     = {st.sh[`RDO_SR_BITS-2:0], st.acc[st.sh_cnt - 4'h1]};
                next_st.sh_cnt = st.sh_cnt - 4'h1;
                if (st.sh_cnt == 4'h1)
                begin
                    next_st.state = RDO_IDLE;
                    next_st.acc   = `RDO_SR_RST;
                    next_st.acc_n = 4'h0;
                end
            end
            default:
            begin
                next_st.state = RDO_IDLE;
            end
        endcase

        // Parallel moves into the hold register
        if (xa_evt)
        begin
            if (word2)
                next_st.hold[`RDO_W2_A_MSB:`RDO_W2_A_LSB] = st.sh[`RDO_W2_A_SRMSB:0];
            else
                next_st.hold[`RDO_W13_A_MSB:`RDO_W13_A_LSB] = st.sh[`RDO_W13_A_SRMSB:0];
        end
        if (xb_evt)
        begin
            if (word2)
                next_st.hold[`RDO_W2_B_MSB:0] = st.sh[`RDO_W2_B_MSB:0];
            else
                next_st.hold[`RDO_W13_B_MSB:0] = st.sh[`RDO_W13_B_MSB:0];
        end
        if (clr_evt)
            next_st.hold = `RDO_HOLD_RST;

        next_st.ready = xb_evt;
        next_st.clear = clr_evt;
    end

    // Word handling repeats for frames eight to ten via the same masks
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            st.strb_s1   <= 1'b1;
            st.strb_s2   <= 1'b1;
            st.strb_s3   <= 1'b1;
            st.strb_f    <= 1'b1;
            st.strb_prev <= 1'b1;
            st.lock_s1   <= 1'b0;
            st.lock_s2   <= 1'b0;
            st.lock_s3   <= 1'b0;
            st.lock_f    <= 1'b0;
            st.mark_s1   <= `RDO_MARK_RST;
            st.mark_s2   <= `RDO_MARK_RST;
            st.mark_s3   <= `RDO_MARK_RST;
            st.mark_f    <= `RDO_MARK_RST;
            st.state     <= RDO_IDLE;
            st.acc       <= `RDO_SR_RST;
            st.acc_n     <= 4'h0;
            st.sh        <= `RDO_SR_RST;
            st.sh_cnt    <= 4'h0;
            st.hold      <= `RDO_HOLD_RST;
            st.ready     <= 1'b0;
            st.clear     <= 1'b0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign hold_o  = st.hold;
    assign ready_o = st.ready;
    assign clear_o = st.clear;

    // Checks
    localparam int shift_lo = 1;
    localparam int shift_hi = 12;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);

    a_ready_single: assert property (st.ready |=> !st.ready)
        else $error("ready held longer than one cycle");

    a_ready_cause: assert property (xb_evt |=> st.ready && ready_o)
        else $error("second-part transfer did not raise ready");

    a_ready_only_xb: assert property (st.ready |-> $past(blank_edge) && !$past(st.lock_f))
        else $error("ready without qualified strobe");

    a_clear_hold: assert property (clr_evt |=> st.hold == `RDO_HOLD_RST && st.clear)
        else $error("hold not cleared by clear pulse");

    a_strobe_gate: assert property ((ready_o || clear_o) |-> !$past(st.strb_s3, 2) && $past(st.strb_prev))
        else $error("pulse without blank strobe edge");

    a_lsb_last: assert property (st.state == RDO_SHIFT && st.sh_cnt == 4'h1 |=> st.sh[0] == $past(st.acc[0]))
        else $error("least significant bit not last in");

    a_shift_ends: assert property ($rose(st.state == RDO_SHIFT) |-> ##[shift_lo:shift_hi] st.state == RDO_IDLE)
        else $error("serial load did not finish");

    a_part_a_w2: assert property (xa_evt && word2 && !clr_evt |=> st.hold[14:12] == $past(st.sh[2:0]))
        else $error("word two first part misplaced");

    a_part_a_w13: assert property (xa_evt && !word2 && !clr_evt |=> st.hold[14:9] == $past(st.sh[5:0]))
        else $error("first part misplaced");

    a_part_b_keep: assert property (xb_evt && !word2 && !clr_evt |=> st.hold[14:9] == $past(st.hold[14:9]))
        else $error("second part overwrote first part");

    a_part_b_w2: assert property (xb_evt && word2 && !clr_evt |=> st.hold[11:0] == $past(st.sh[11:0]))
        else $error("word two second part misplaced");

    a_clear_single: assert property (clear_o |=> !clear_o)
        else $error("clear held longer than one cycle");

    a_clear_zero: assert property (clear_o |-> hold_o == `RDO_HOLD_RST)
        else $error("clear pulse with hold not empty");

    a_lock_clear: assert property (clr_evt && st.lock_f |=> clear_o)
        else $error("clear blocked by lockout");

    a_lock_no_ready: assert property (st.lock_f |=> !st.ready)
        else $error("ready during lockout");

    a_lock_no_xfer: assert property (st.lock_f && !clr_evt |=> st.hold == $past(st.hold))
        else $error("transfer during lockout");

    a_hold_quiet: assert property (!blank_edge |=> st.hold == $past(st.hold))
        else $error("hold changed without strobe edge");

    a_part_b_w13: assert property (xb_evt && !word2 && !clr_evt |=> st.hold[8:0] == $past(st.sh[8:0]))
        else $error("second part misplaced");

    a_part_a_keep: assert property (xa_evt && !word2 && !clr_evt |=> st.hold[8:0] == $past(st.hold[8:0]))
        else $error("first part overwrote low stages");

    a_w2_b_keep: assert property (xb_evt && word2 && !clr_evt |=> st.hold[14:12] == $past(st.hold[14:12]))
        else $error("word two second part overwrote first part");

    a_shift_zero: assert property (st.state == RDO_IDLE && part_go_i && st.acc_n != 4'h0 |=> st.sh == `RDO_SR_RST)
        else $error("shift register not emptied at load start");

    a_sh_idle: assert property (st.state == RDO_IDLE && !part_go_i |=> st.sh == $past(st.sh))
        else $error("shift register changed while idle");

    a_acc_keep: assert property (st.state == RDO_SHIFT && st.sh_cnt != 4'h1 |=> st.acc == $past(st.acc))
        else $error("accumulator changed while shifting");

    a_sh_count: assert property (st.state == RDO_SHIFT |-> st.sh_cnt != 4'h0 && st.sh_cnt <= 4'hC)
        else $error("shift count out of range");

    a_acc_room: assert property (st.acc_n <= 4'hC)
        else $error("accumulator overfilled");

    a_one_state: assert property ($onehot(st.state))
        else $error("state code not one-hot");

    a_mark_agree: assert property (st.mark_s2 == st.mark_s3 |=> st.mark_f == $past(st.mark_s3))
        else $error("marker filter did not follow agreed stages");

    a_strb_agree: assert property (st.strb_s2 == st.strb_s3 |=> st.strb_f == $past(st.strb_s3))
        else $error("strobe filter did not follow agreed stages");

    a_ready_clear: assert property (st.ready |-> !$past(st.lock_f, 2) || !$past(st.lock_s3, 2))
        else $error("ready after locked strobe");

    c_clear: cover property (clr_evt ##1 clear_o);
    c_ready: cover property (xb_evt ##1 st.ready);
    c_word_cycle: cover property (xa_evt ##[1:1000] xb_evt ##[1:1000] clr_evt);
    c_lockout: cover property (st.lock_f && blank_edge && |(st.mark_f & `RDO_XB_MASK));
    c_stall: cover property (tri_valid_i && !tri_ready_o);

endmodule : rdo_readout

`default_nettype wire

// [rdo_stream_if.sv]
/*
 Valid/ready carrier for three-bit data groups between the readout blocks.
 Assumes both ends run on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
`include "rdo_defs.svh"

interface rdo_stream_if;
    logic                       valid;
    logic                       ready;
    logic [`RDO_TRI_BITS-1:0]   data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : rdo_stream_if

`default_nettype wire

// [testbench.sv]
/*
 Self-checking bench for the readout control with the experimenter model.
 Assumes marker, strobe and lockout inputs may be driven on falling clk_i edges.
*/
`timescale 1ns/10ps
`default_nettype none

module testbench;
    logic          clk_i;
    logic          nrst_i      = 1'b0;
    logic          strobe_n_i  = 1'b1;
    logic [17:0]   marker_i    = 18'h00000;
    logic          lockout_i   = 1'b0;
    logic [2:0]    tri_data_i  = 3'h0;
    logic          tri_valid_i = 1'b0;
    logic          part_go_i   = 1'b0;
    logic          tri_ready_o;
    logic [14:0]   hold_o;
    logic          ready_o;
    logic          clear_o;
    logic [14:0]   far_word;
    logic [7:0]    far_cnt;
    logic [7:0]    exp_cnt     = 8'h00;
    int            n_errors    = 0;
    int            compares    = 0;
    int            n_rdy       = 0;
    int            n_clr       = 0;
    int            cycles      = 0;

    rdo_readout DUT (.clk_i(clk_i), .nrst_i(nrst_i), .strobe_n_i(strobe_n_i), .marker_i(marker_i),
        .lockout_i(lockout_i), .tri_data_i(tri_data_i), .tri_valid_i(tri_valid_i),
        .tri_ready_o(tri_ready_o), .part_go_i(part_go_i), .hold_o(hold_o), .ready_o(ready_o),
        .clear_o(clear_o));
    rdo_exp_model u_far (.clk_i(clk_i), .nrst_i(nrst_i), .ready_i(ready_o), .word_i(hold_o),
        .cmd_o(), .word_o(far_word), .cnt_o(far_cnt));

    initial
    begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    always @(negedge clk_i)
    begin
        n_rdy += (ready_o === 1'b1);
        n_clr += (clear_o === 1'b1);
    end

    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_errors++;
            complete_run();
        end
    end

    task complete_run;
        if (n_errors == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : complete_run

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp)
        begin
            $display("[ERR] %s expected %h seen %h", name, exp, got);
            n_errors++;
        end
    endtask : chk

    task automatic send_group(input logic [2:0] d);
        int t;
        t = 0;
        @(negedge clk_i);
        tri_valid_i = 1'b1;
        tri_data_i = d;
        while (tri_ready_o !== 1'b1 && t < 50)
        begin
            @(negedge clk_i);
            t++;
        end
        chk("tri_ready_o", 16'h0001, {15'h0000, tri_ready_o});
        @(negedge clk_i);
        tri_valid_i = 1'b0;
        tri_data_i = ~d;
    endtask : send_group

    task automatic pulse_go;
        @(negedge clk_i);
        part_go_i = 1'b1;
        @(negedge clk_i);
        part_go_i = 1'b0;
        repeat (16) @(negedge clk_i);
    endtask : pulse_go

    task automatic load_part(input logic [11:0] v, input int ng);
        for (int g = ng - 1; g >= 0; g--)
            send_group(v[g*3 +: 3]);
        repeat (3) @(negedge clk_i);
        pulse_go();
    endtask : load_part

    task automatic strobe_mark(input int idx, output int dr, output int dc);
        int r0;
        int c0;
        r0 = n_rdy;
        c0 = n_clr;
        @(negedge clk_i);
        if (idx >= 0)
            marker_i[idx] = 1'b1;
        repeat (5) @(negedge clk_i);
        strobe_n_i = 1'b0;
        repeat (8) @(negedge clk_i);
        strobe_n_i = 1'b1;
        repeat (5) @(negedge clk_i);
        marker_i = 18'h00000;
        repeat (5) @(negedge clk_i);
        dr = n_rdy - r0;
        dc = n_clr - c0;
    endtask : strobe_mark

    task automatic run_word(input int a_mk, input int b_mk, input int c_mk, input bit w2,
                            input logic [14:0] w);
        int dr;
        int dc;
        logic [14:0] hi;
        hi = w2 ? (w & 15'h7000) : (w & 15'h7E00);
        load_part(w2 ? {9'h000, w[14:12]} : {6'h00, w[14:9]}, w2 ? 1 : 2);
        strobe_mark(a_mk, dr, dc);
        chk("hold_o first part", {1'b0, hi}, {1'b0, hold_o});
        chk("ready first part", 16'h0000, dr[15:0]);
        load_part(w2 ? w[11:0] : {3'h0, w[8:0]}, w2 ? 4 : 3);
        strobe_mark(b_mk, dr, dc);
        exp_cnt++;
        chk("hold_o word", {1'b0, w}, {1'b0, hold_o});
        chk("ready pulses", 16'h0001, dr[15:0]);
        chk("far word", {1'b0, w}, {1'b0, far_word});
        chk("far count", {8'h00, exp_cnt}, {8'h00, far_cnt});
        strobe_mark(c_mk, dr, dc);
        chk("hold_o cleared", 16'h0000, {1'b0, hold_o});
        chk("clear pulses", 16'h0001, dc[15:0]);
    endtask : run_word

    task automatic words_all;
        for (int i = 0; i < 6; i++)
            run_word(3*i, 3*i+1, 3*i+2, (i % 3) == 1, 15'h2B5D ^ (15'h0F31 * i[14:0]));
    endtask : words_all

    task automatic buffer_stall;
        int dr;
        int dc;
        for (int g = 0; g < 6; g++)
            send_group(3'(g + 1));
        @(negedge clk_i);
        tri_valid_i = 1'b1;
        tri_data_i = 3'h7;
        repeat (4) @(negedge clk_i);
        chk("tri_ready_o full", 16'h0000, {15'h0000, tri_ready_o});
        tri_valid_i = 1'b0;
        tri_data_i = 3'h0;
        pulse_go();
        repeat (6) @(negedge clk_i);
        chk("tri_ready_o drained", 16'h0001, {15'h0000, tri_ready_o});
        strobe_mark(4, dr, dc);
        exp_cnt++;
        chk("hold_o twelve bits", 16'h029C, {1'b0, hold_o});
        pulse_go();
        strobe_mark(0, dr, dc);
        chk("hold_o after drain", {1'b0, 6'h2E, 9'h09C}, {1'b0, hold_o});
        strobe_mark(2, dr, dc);
        chk("hold_o cleared", 16'h0000, {1'b0, hold_o});
    endtask : buffer_stall

    task automatic gating;
        int dr;
        int dc;
        load_part(12'h02D, 2);
        strobe_mark(0, dr, dc);
        chk("hold_o loaded", 16'h5A00, {1'b0, hold_o});
        strobe_mark(-1, dr, dc);
        chk("hold_o strobe only", 16'h5A00, {1'b0, hold_o});
        @(negedge clk_i);
        marker_i[2] = 1'b1;
        repeat (20) @(negedge clk_i);
        marker_i = 18'h00000;
        repeat (5) @(negedge clk_i);
        chk("hold_o marker only", 16'h5A00, {1'b0, hold_o});
        lockout_i = 1'b1;
        load_part(12'h1FF, 3);
        strobe_mark(1, dr, dc);
        chk("hold_o locked", 16'h5A00, {1'b0, hold_o});
        chk("ready locked", 16'h0000, dr[15:0]);
        strobe_mark(2, dr, dc);
        chk("clear locked", 16'h0001, dc[15:0]);
        chk("hold_o locked clear", 16'h0000, {1'b0, hold_o});
        lockout_i = 1'b0;
        chk("far count", {8'h00, exp_cnt}, {8'h00, far_cnt});
    endtask : gating

    initial
    begin
        repeat (4) @(negedge clk_i);
        chk("hold_o reset", 16'h0000, {1'b0, hold_o});
        chk("tri_ready_o reset", 16'h0001, {15'h0000, tri_ready_o});
        nrst_i = 1'b1;
        repeat (3) @(negedge clk_i);
        words_all();
        buffer_stall();
        gating();
        complete_run();
    end
endmodule : testbench

`default_nettype wire
